// File: pkg/lkd_pkg.sv
// Functional notes
// - With the sleep bit at 0 the timing source runs and the common and segment outputs carry drive waveforms.
// - With the sleep bit at 1 the RC timing source stops except during a key scan and all common and segment outputs sit low.
// - In sleep with the external source selected the external clock is ignored except during a key scan.
// - In key-scan standby, scan-level code n holds the first n of the six scan outputs low and the rest high.
// - No scan strobe is ever driven on a scan output that the scan-level field holds low.
// - With the scan-disable bit at 0 a key scan starts when a pressed key sits on a scan line held high and no read request is pending.
// - With the scan-disable bit at 1 no scan runs, key data clears to zero and a pending read request is withdrawn.
// - The scan/segment field turns the first 0 to 3 shared scan pins into segment outputs, leaving 30, 25, 20 or 15 keys.
// - The port-select field turns the first 0 to 4 shared segment pins into general-purpose outputs.
// - A general-purpose pin follows display bit D1, D4, D7, D10 in 1/3 duty or D1, D5, D9, D13 in 1/4 duty.
// - A general-purpose pin drives the LCD supply level for a 1 and the low supply level for a 0.
// - The blank bit at 1 drives segment-off waveforms on every segment output; at 0 the display shows.
// - The bias bit selects 1/3 bias at 0 and 1/2 bias at 1.
// - The duty bit selects 1/4 duty with the fourth backplane pin as common at 0, 1/3 duty with it as segment at 1.
// - The frame-rate field divides the timing source by 768, 576, 384, 288 or 192 for codes 0 to 4.
package lkd_pkg;

    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_DISP     = 8'h04;
    localparam logic [7:0]  REG_KEYS     = 8'h08;
    localparam logic [7:0]  REG_IRQ_STAT = 8'h0c;
    localparam logic [7:0]  REG_IRQ_MASK = 8'h10;
    localparam logic [7:0]  REG_STATE    = 8'h14;

    localparam int          NUM_SCAN     = 6;
    localparam int          NUM_KEYIN    = 5;
    localparam int          NUM_KEYS     = 30;
    localparam int          NUM_SHARED   = 3;
    localparam int          NUM_PORT     = 4;
    localparam int          DISP_W       = 16;
    localparam int          DIV_W        = 10;
    localparam int          IRQ_W        = 2;
    localparam int          IRQ_SCAN     = 0;
    localparam int          IRQ_CANCEL   = 1;

    // Step count at which each scan line's returns are sampled; each line is strobed SCAN_STEP + 1 cycles
    localparam logic [3:0]  SCAN_STEP    = 4'h8;
    localparam logic [2:0]  LAST_LINE    = 3'h5;
    localparam logic [2:0]  PORT_MAX     = 3'h4;

    localparam logic [9:0]  DIV_768      = 10'h300;
    localparam logic [9:0]  DIV_576      = 10'h240;
    localparam logic [9:0]  DIV_384      = 10'h180;
    localparam logic [9:0]  DIV_288      = 10'h120;
    localparam logic [9:0]  DIV_192      = 10'h0c0;

    typedef struct packed {
        logic       ext_clk_sel;
        logic [2:0] frame_rate_field;
        logic       duty_select_bit;
        logic       bias_select_bit;
        logic       segment_blank_bit;
        logic [2:0] port_select_field;
        logic [1:0] scan_or_segment_field;
        logic       scan_disable_bit;
        logic [2:0] scan_standby_level_field;
        logic       sleep_select_bit;
    } lkd_ctrl_t;

    localparam int          CTRL_W       = $bits(lkd_ctrl_t);
    localparam lkd_ctrl_t   CTRL_RST     = '{default: '0};

    // Divider load for each frame-rate code; reserved codes fall back to the slowest
    function automatic logic [9:0] frame_div(input logic [2:0] code);
        case (code)
            3'h0:    frame_div = DIV_768;
            3'h1:    frame_div = DIV_576;
            3'h2:    frame_div = DIV_384;
            3'h3:    frame_div = DIV_288;
            3'h4:    frame_div = DIV_192;
            default: frame_div = DIV_768;
        endcase
    endfunction

    typedef enum logic {
        SCAN_IDLE,
        SCAN_RUN
    } lkd_scan_t;

endpackage

// File: rtl/lkd_top.sv
`timescale 1ns/1ns
module lkd_top (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic [4:0]              key_in_i,
    output logic      [5:0]              key_strobe_outputs_o,
    output logic      [2:0]              shared_scan_is_seg_o,
    output logic      [3:0]              shared_port_is_gp_o,
    output logic      [3:0]              shared_port_pins_o,
    output logic                         serial_out_o,
    output logic                         serial_out_oe_n_o,
    output logic                         osc_run_o,
    output logic                         ext_clk_accept_o,
    output logic                         lcd_drive_en_o,
    output logic                         segment_off_o,
    output logic                         bias_half_o,
    output logic                         duty_third_o,
    output logic                         fourth_backplane_is_seg_o,
    output logic                         frame_tick_o,
    output lkd_pkg::lkd_ctrl_t           ctrl_o,
    output logic                         irq_o
);

    lkd_pkg::lkd_ctrl_t                  ctrl_r;
    logic [lkd_pkg::DISP_W-1:0]          disp_r;
    logic [lkd_pkg::NUM_KEYS-1:0]        keys_r;
    logic                                req_r;
    logic [lkd_pkg::IRQ_W-1:0]           stat_r;
    logic [lkd_pkg::IRQ_W-1:0]           mask_r;
    lkd_pkg::lkd_scan_t                  scan_st_r;
    logic [2:0]                          line_r;
    logic [3:0]                          step_r;
    logic [9:0]                          div_cnt_r;
    logic                                frame_tick_r;
    logic [3:0]                          port_gp_r;
    logic [31:0]                         rdata_nxt;
    logic                                wb_req;
    logic                                wr_ctrl;
    logic                                wr_disp;
    logic                                wr_stat;
    logic                                wr_mask;
    logic                                rd_keys;
    logic [5:0]                          standby_hi;
    logic [5:0]                          scan_capable;
    logic [5:0]                          eligible;
    logic                                scan_active;
    logic                                scan_start;
    logic                                scan_done;
    logic                                cancel;
    logic [lkd_pkg::IRQ_W-1:0]           stat_set;
    logic [3:0]                          gp_level;
    logic [31:0]                         wmask;

    assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr_ctrl = wb_req && wb_we_i && (wb_adr_i == lkd_pkg::REG_CTRL);
    assign wr_disp = wb_req && wb_we_i && (wb_adr_i == lkd_pkg::REG_DISP);
    assign wr_stat = wb_req && wb_we_i && (wb_adr_i == lkd_pkg::REG_IRQ_STAT);
    assign wr_mask = wb_req && wb_we_i && (wb_adr_i == lkd_pkg::REG_IRQ_MASK);
    assign rd_keys = wb_req && !wb_we_i && (wb_adr_i == lkd_pkg::REG_KEYS);

    // Bus answer: one wait state, ack for one cycle, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (wb_adr_i)
            lkd_pkg::REG_CTRL:     rdata_nxt = {{(32 - lkd_pkg::CTRL_W){1'b0}}, ctrl_r};
            lkd_pkg::REG_DISP:     rdata_nxt = {16'h0000, disp_r};
            lkd_pkg::REG_KEYS:     rdata_nxt = {2'h0, keys_r};
            lkd_pkg::REG_IRQ_STAT: rdata_nxt = {30'h0000_0000, stat_r};
            lkd_pkg::REG_IRQ_MASK: rdata_nxt = {30'h0000_0000, mask_r};
            lkd_pkg::REG_STATE:    rdata_nxt = {29'h0000_0000, osc_run_o, req_r, scan_active};
            default:               rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= rdata_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= lkd_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= (ctrl_r & ~wmask[lkd_pkg::CTRL_W-1:0]) | (wb_dat_i[lkd_pkg::CTRL_W-1:0] & wmask[lkd_pkg::CTRL_W-1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            disp_r <= '0;
        end else if (wr_disp) begin
            disp_r <= (disp_r & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_r <= '0;
        end else if (wr_mask && wb_sel_i[0]) begin
            mask_r <= wb_dat_i[lkd_pkg::IRQ_W-1:0];
        end
    end

    // Scan-level code n pulls the first n lines low; code 7 also ends all low
    always_comb begin
        for (int i = 0; i < lkd_pkg::NUM_SCAN; i++) begin
            standby_hi[i] = (32'(ctrl_r.scan_standby_level_field) <= i);
        end
    end

    // Shared pins turned into segments leave the key matrix
    always_comb begin
        for (int i = 0; i < lkd_pkg::NUM_SCAN; i++) begin
            scan_capable[i] = (i >= lkd_pkg::NUM_SHARED) ||
                              (32'(ctrl_r.scan_or_segment_field) <= i);
        end
    end

    assign eligible             = standby_hi & scan_capable;
    assign shared_scan_is_seg_o = ~scan_capable[2:0];
    assign scan_active          = (scan_st_r == lkd_pkg::SCAN_RUN);
    assign cancel               = ctrl_r.scan_disable_bit && (req_r || scan_active);
    assign scan_start           = !scan_active && !ctrl_r.scan_disable_bit && !req_r &&
                                  (|key_in_i) && (|eligible);
    assign scan_done            = scan_active && !ctrl_r.scan_disable_bit &&
                                  (step_r == lkd_pkg::SCAN_STEP) && (line_r == lkd_pkg::LAST_LINE);

    // Walk the six lines, strobing each for a fixed time and sampling the returns
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_st_r <= lkd_pkg::SCAN_IDLE;
            line_r    <= '0;
            step_r    <= '0;
        end else begin
            unique case (scan_st_r)
                lkd_pkg::SCAN_IDLE: begin
                    line_r <= '0;
                    step_r <= '0;
                    if (scan_start) begin
                        scan_st_r <= lkd_pkg::SCAN_RUN;
                    end
                end
                lkd_pkg::SCAN_RUN: begin
                    if (ctrl_r.scan_disable_bit || scan_done) begin
                        scan_st_r <= lkd_pkg::SCAN_IDLE;
                    end else if (step_r == lkd_pkg::SCAN_STEP) begin
                        step_r <= '0;
                        line_r <= line_r + 3'h1;
                    end else begin
                        step_r <= step_r + 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            keys_r <= '0;
        end else if (ctrl_r.scan_disable_bit) begin
            keys_r <= '0;
        end else if (scan_active && step_r == lkd_pkg::SCAN_STEP) begin
            keys_r[line_r * lkd_pkg::NUM_KEYIN +: lkd_pkg::NUM_KEYIN] <= eligible[line_r] ? key_in_i : 5'h00;
        end
    end

    // Read request: set by a finished scan, taken back by a key read; set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_r <= 1'b0;
        end else if (ctrl_r.scan_disable_bit) begin
            req_r <= 1'b0;
        end else if (scan_done) begin
            req_r <= 1'b1;
        end else if (rd_keys) begin
            req_r <= 1'b0;
        end
    end

    // Open-drain serial output pulls low while key data waits, else released
    assign serial_out_o      = 1'b0;
    assign serial_out_oe_n_o = !req_r;

    always_comb begin
        key_strobe_outputs_o = eligible;
        if (scan_active) begin
            key_strobe_outputs_o = eligible & (6'h01 << line_r);
        end
    end

    assign stat_set = {cancel, scan_done};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_r <= '0;
        end else begin
            stat_r <= (stat_r & ~(wr_stat && wb_sel_i[0] ? wb_dat_i[lkd_pkg::IRQ_W-1:0] : 2'h0)) | stat_set;
        end
    end

    assign irq_o = |(stat_r & mask_r);

    // Timing source and drive state
    assign osc_run_o        = !ctrl_r.sleep_select_bit || scan_active;
    assign ext_clk_accept_o = ctrl_r.ext_clk_sel && (!ctrl_r.sleep_select_bit || scan_active);
    assign lcd_drive_en_o   = !ctrl_r.sleep_select_bit;
    assign segment_off_o    = ctrl_r.segment_blank_bit;
    assign bias_half_o      = ctrl_r.bias_select_bit;
    assign duty_third_o     = ctrl_r.duty_select_bit;
    assign fourth_backplane_is_seg_o = ctrl_r.duty_select_bit;
    assign ctrl_o           = ctrl_r;

    // Frame divider runs only while the display is driven
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_r    <= '0;
            frame_tick_r <= 1'b0;
        end else if (!lcd_drive_en_o) begin
            div_cnt_r    <= '0;
            frame_tick_r <= 1'b0;
        end else if (div_cnt_r >= lkd_pkg::frame_div(ctrl_r.frame_rate_field) - 10'h001) begin
            div_cnt_r    <= '0;
            frame_tick_r <= 1'b1;
        end else begin
            div_cnt_r    <= div_cnt_r + 10'h001;
            frame_tick_r <= 1'b0;
        end
    end

    assign frame_tick_o = frame_tick_r;

    // General-purpose port pins, lowest first; reserved codes take all four
    always_comb begin
        for (int i = 0; i < lkd_pkg::NUM_PORT; i++) begin
            gp_level[i] = ctrl_r.duty_select_bit ? disp_r[3 * i] : disp_r[4 * i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_gp_r          <= '0;
            shared_port_pins_o <= '0;
        end else begin
            for (int i = 0; i < lkd_pkg::NUM_PORT; i++) begin
                port_gp_r[i] <= (ctrl_r.port_select_field > 3'(i)) ||
                                (ctrl_r.port_select_field > lkd_pkg::PORT_MAX);
            end
            shared_port_pins_o <= gp_level;
        end
    end

    assign shared_port_is_gp_o = port_gp_r;

endmodule // lkd_top

// File: sim/lkd_key_matrix.sv
`timescale 1ns/1ns
module lkd_key_matrix (
    input  wire logic [5:0]  key_strobe_i,
    input  wire logic [2:0]  is_seg_i,
    input  wire logic [29:0] pressed_i,
    output logic      [4:0]  key_ret_o
);
    // Returns have pull-downs, so an unstrobed line reads low
    always_comb begin
        key_ret_o = 5'h0;
        for (int l = 0; l < 6; l++) begin
            if (key_strobe_i[l] && !(l < 3 && is_seg_i[l % 3])) begin
                key_ret_o = key_ret_o | pressed_i[l*5 +: 5];
            end
        end
    end
endmodule // lkd_key_matrix

// File: sim/lkd_top_sva.sv
`timescale 1ns/1ns
module lkd_top_sva (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_ack_o,
    input wire logic [5:0]         key_strobe_outputs_o,
    input wire logic [2:0]         shared_scan_is_seg_o,
    input wire logic [3:0]         shared_port_is_gp_o,
    input wire logic               serial_out_oe_n_o,
    input wire logic               lcd_drive_en_o,
    input wire logic               osc_run_o,
    input wire logic               ext_clk_accept_o,
    input wire logic               segment_off_o,
    input wire logic               bias_half_o,
    input wire logic               duty_third_o,
    input wire logic               fourth_backplane_is_seg_o,
    input wire lkd_pkg::lkd_ctrl_t ctrl_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [5:0] low_m;
    assign low_m = 6'((7'h1 << ctrl_o.scan_standby_level_field) - 7'h1);
    function automatic logic [3:0] gpx(input logic [2:0] p);
        gpx = (p > 3'h4) ? 4'hf : ~(4'hf << p);
    endfunction
    a_ack_after_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_normal_drive_on: assert property (!ctrl_o.sleep_select_bit |-> lcd_drive_en_o && (osc_run_o || ext_clk_accept_o))
        else $error("normal mode without drive");
    a_sleep_drive_off: assert property (ctrl_o.sleep_select_bit |-> !lcd_drive_en_o)
        else $error("sleep mode still driving");
    a_low_lines_quiet: assert property ((key_strobe_outputs_o & low_m) == 6'h0)
        else $error("strobe on a line held low");
    a_disable_standby: assert property (ctrl_o.scan_disable_bit[*3] |->
        ((key_strobe_outputs_o ^ ~low_m) & ~{3'h0, shared_scan_is_seg_o}) == 6'h0)
        else $error("scan activity while disabled");
    a_disable_drops_req: assert property (ctrl_o.scan_disable_bit |=> serial_out_oe_n_o)
        else $error("read request kept while disabled");
    a_scan_seg_map: assert property (shared_scan_is_seg_o == 3'(3'h7 >> (2'h3 - ctrl_o.scan_or_segment_field)))
        else $error("scan pin roles wrong");
    a_port_gp_map: assert property (1'b1 |=> shared_port_is_gp_o == gpx($past(ctrl_o.port_select_field)))
        else $error("port pin roles wrong");
    a_blank_follow: assert property (segment_off_o == ctrl_o.segment_blank_bit)
        else $error("blank output wrong");
    a_bias_follow: assert property (bias_half_o == ctrl_o.bias_select_bit)
        else $error("bias output wrong");
    a_duty_follow: assert property ((duty_third_o == ctrl_o.duty_select_bit) &&
        (fourth_backplane_is_seg_o == ctrl_o.duty_select_bit))
        else $error("duty output wrong");
    a_ext_clk_gate: assert property (ext_clk_accept_o == (ctrl_o.ext_clk_sel && osc_run_o))
        else $error("external clock gating wrong");
    c_read_req: cover property ($fell(serial_out_oe_n_o));
    c_sleep: cover property (ctrl_o.sleep_select_bit && !lcd_drive_en_o);
    c_port_all: cover property (shared_port_is_gp_o == 4'hf);
endmodule // lkd_top_sva
bind lkd_top lkd_top_sva lkd_top_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .key_strobe_outputs_o(key_strobe_outputs_o), .shared_scan_is_seg_o(shared_scan_is_seg_o),
    .shared_port_is_gp_o(shared_port_is_gp_o), .serial_out_oe_n_o(serial_out_oe_n_o), .lcd_drive_en_o(lcd_drive_en_o),
    .osc_run_o(osc_run_o), .ext_clk_accept_o(ext_clk_accept_o), .segment_off_o(segment_off_o),
    .bias_half_o(bias_half_o), .duty_third_o(duty_third_o), .fourth_backplane_is_seg_o(fourth_backplane_is_seg_o),
    .ctrl_o(ctrl_o));

// File: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, serial_out_oe_n_o;
    logic frame_tick_o, irq_o, lcd_drive_en_o, osc_run_o;
    logic segment_off_o, bias_half_o, duty_third_o, fourth_backplane_is_seg_o, ext_clk_accept_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, shared_port_is_gp_o, shared_port_pins_o;
    logic [31:0] wb_dat_i, wb_dat_o, rdat;
    logic [4:0] key_in_i;
    logic [5:0] key_strobe_outputs_o;
    logic [2:0] shared_scan_is_seg_o;
    logic [29:0] pressed;
    lkd_pkg::lkd_ctrl_t c;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int dv[5] = '{768, 576, 384, 288, 192};

    lkd_top lkd_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .key_in_i(key_in_i), .key_strobe_outputs_o(key_strobe_outputs_o),
        .shared_scan_is_seg_o(shared_scan_is_seg_o), .shared_port_is_gp_o(shared_port_is_gp_o),
        .shared_port_pins_o(shared_port_pins_o), .serial_out_o(), .serial_out_oe_n_o(serial_out_oe_n_o),
        .osc_run_o(osc_run_o), .ext_clk_accept_o(ext_clk_accept_o), .lcd_drive_en_o(lcd_drive_en_o),
        .segment_off_o(segment_off_o), .bias_half_o(bias_half_o), .duty_third_o(duty_third_o),
        .fourth_backplane_is_seg_o(fourth_backplane_is_seg_o), .frame_tick_o(frame_tick_o),
        .ctrl_o(), .irq_o(irq_o));
    lkd_key_matrix lkd_key_matrix_inst (.key_strobe_i(key_strobe_outputs_o), .is_seg_i(shared_scan_is_seg_o),
        .pressed_i(pressed), .key_ret_o(key_in_i));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        #1;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wreq();
        int n;
        n = 0;
        while (serial_out_oe_n_o !== 1'b0 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        #1;
    endtask

    task automatic tick(output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (frame_tick_o !== 1'b1 && n < 2000);
    endtask

    task automatic t_levels();
        for (int l = 0; l < 7; l++) begin
            c = '0;
            c.scan_standby_level_field = 3'(l);
            c.scan_or_segment_field = 2'(l % 4);
            wb(1'b1, lkd_pkg::REG_CTRL, 32'(c));
            chk(key_strobe_outputs_o, 6'(6'h3f << l));
            chk(shared_scan_is_seg_o, 3'(~(3'h7 << (l % 4))));
        end
    endtask

    task automatic t_ports();
        logic [15:0] pat;
        logic [3:0] e;
        logic [3:0] m;
        for (int d = 0; d < 2; d++) begin
            for (int p = 0; p < 5; p++) begin
                for (int k = 0; k < 2; k++) begin
                    pat = k ? 16'hedb6 : 16'h1249;
                    m = ~(4'hf << p);
                    for (int i = 0; i < 4; i++) e[i] = pat[d ? 3*i : 4*i];
                    c = '0;
                    c.duty_select_bit = d[0];
                    c.port_select_field = 3'(p);
                    c.segment_blank_bit = k[0];
                    c.bias_select_bit = d[0];
                    c.ext_clk_sel = k[0];
                    wb(1'b1, lkd_pkg::REG_DISP, {16'h0, pat});
                    wb(1'b1, lkd_pkg::REG_CTRL, 32'(c));
                    chk(shared_port_is_gp_o, m);
                    chk({segment_off_o, bias_half_o}, {k[0], d[0]});
                    chk({duty_third_o, fourth_backplane_is_seg_o, ext_clk_accept_o}, {d[0], d[0], k[0]});
                    chk(shared_port_pins_o & m, e & m);
                end
            end
        end
    endtask

    task automatic t_scan();
        c = '0;
        c.scan_standby_level_field = 3'h3;
        wb(1'b1, lkd_pkg::REG_CTRL, 32'(c));
        wb(1'b1, lkd_pkg::REG_IRQ_MASK, 32'h1);
        pressed <= 30'h20;
        idle(150);
        chk(serial_out_oe_n_o, 1'b1);
        pressed <= 30'h400020;
        wreq();
        chk(serial_out_oe_n_o, 1'b0);
        chk(irq_o, 1'b1);
        wb(1'b1, lkd_pkg::REG_IRQ_MASK, 32'h0);
        chk(irq_o, 1'b0);
        wb(1'b1, lkd_pkg::REG_IRQ_MASK, 32'h1);
        pressed <= '0;
        wb(1'b0, lkd_pkg::REG_KEYS, 32'h0);
        chk(rdat, 32'h400000);
        chk(serial_out_oe_n_o, 1'b1);
        wb(1'b1, lkd_pkg::REG_IRQ_STAT, 32'h1);
        chk(irq_o, 1'b0);
    endtask

    task automatic t_disable();
        c = '0;
        wb(1'b1, lkd_pkg::REG_CTRL, 32'(c));
        pressed <= 30'h10;
        wreq();
        c.scan_disable_bit = 1'b1;
        wb(1'b1, lkd_pkg::REG_CTRL, 32'(c));
        idle(2);
        chk(serial_out_oe_n_o, 1'b1);
        wb(1'b0, lkd_pkg::REG_KEYS, 32'h0);
        chk(rdat, 32'h0);
        idle(150);
        chk(serial_out_oe_n_o, 1'b1);
        pressed <= '0;
        wb(1'b1, lkd_pkg::REG_IRQ_STAT, 32'h3);
    endtask

    task automatic t_frame();
        int n;
        // Only defined frame codes are loaded
        for (int f = 0; f < 5; f++) begin
            c = '0;
            c.frame_rate_field = 3'(f);
            wb(1'b1, lkd_pkg::REG_CTRL, 32'(c));
            tick(n);
            tick(n);
            chk(n, dv[f]);
        end
        c.sleep_select_bit = 1'b1;
        c.ext_clk_sel = 1'b1;
        wb(1'b1, lkd_pkg::REG_CTRL, 32'(c));
        chk({lcd_drive_en_o, osc_run_o, ext_clk_accept_o}, 3'h0);
        idle(2);
        tick(n);
        chk(n, 2000);
        // A key scan in sleep wakes the timing source and the external clock path
        pressed <= 30'h1;
        idle(3);
        chk({lcd_drive_en_o, osc_run_o, ext_clk_accept_o}, 3'h3);
    endtask

    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h0;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        pressed = '0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        idle(1);
        chk({key_strobe_outputs_o, serial_out_oe_n_o, lcd_drive_en_o}, 8'hff);
        wb(1'b0, 8'hfc, 32'h0);
        chk(rdat, 32'h0);
        t_levels();
        t_ports();
        t_scan();
        t_disable();
        t_frame();
        conclude();
    end
endmodule // tb_top
